// File: rtl/load_switch_pkg.sv
// constants and types for the load switch fault sequencer
// assumes a single 10 MHz core clock drives every timer
`default_nettype none
package load_switch_pkg;

	// core clock rate
	localparam int CLK_HZ = 10_000_000;

	// documented delays in their own units
	localparam int SC_CHECK_MS = 7;
	localparam int HICCUP_MS = 70;
	localparam int REPORT_MS = 8;
	localparam int RELEASE_MS = 17;
	localparam int BLANK_US = 370;
	localparam int RECOVER_US = 15;

	// delays as clock counts, whole cycles
	localparam int SC_CHECK_CYC = SC_CHECK_MS * (CLK_HZ / 1000);
	localparam int HICCUP_CYC = HICCUP_MS * (CLK_HZ / 1000);
	localparam int REPORT_CYC = REPORT_MS * (CLK_HZ / 1000);
	localparam int RELEASE_CYC = RELEASE_MS * (CLK_HZ / 1000);
	localparam int BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
	localparam int RECOVER_CYC = RECOVER_US * (CLK_HZ / 1_000_000);

	// timer counter width, enough for the longest delay
	localparam int TIMER_W = 20;

	// bit positions of the synchronised input vector
	localparam int IN_ENABLE = 0;
	localparam int IN_FAST_ON = 1;
	localparam int IN_INPUT_UNDERVOLTAGE_LOCKOUT = 2;
	localparam int IN_OVERTEMP = 3;
	localparam int IN_OCP = 4;
	localparam int IN_CLP = 5;
	localparam int IN_OUT_LOW = 6;
	localparam int IN_REVERSE = 7;
	localparam int IN_COUNT = 8;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_SHUTDOWN = 7'h01,
		ST_PRECHECK = 7'h02,
		ST_RCP_WAIT = 7'h04,
		ST_SOFTSTART = 7'h08,
		ST_ON = 7'h10,
		ST_HICCUP = 7'h20,
		ST_THERMAL = 7'h40
	} seq_state_t;

endpackage : load_switch_pkg
`default_nettype wire

// File: rtl/timer_if.sv
// run/limit/expired link between the sequencer and one delay timer
// assumes owner and timer share the core clock
`timescale 1ns/1ps
`default_nettype none
interface timer_if #(
	parameter int W = 20
);
	logic run;
	logic [W-1:0] limit;
	logic expired;

	// the sequencer owns run and limit
	modport owner (
		output run,
		output limit,
		input expired
	);

	// the timer answers with expired
	modport counter (
		input run,
		input limit,
		output expired
	);
endinterface : timer_if
`default_nettype wire

// File: rtl/delay_timer.sv
// one delay counter: counts while run is high, flags when limit is reached
// assumes run comes from logic on the same clock, no synchroniser needed
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
	parameter int W = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	timer_if.counter tmr
);
	typedef struct packed {
		logic [W-1:0] count;
		logic expired;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	// dropping run restarts from zero, so each use is a fresh interval
	always_comb begin
		next_s = s;
		if (!tmr.run) begin
			next_s.count = '0;
			next_s.expired = 1'b0;
		end else if (s.count != tmr.limit) begin
			next_s.count = s.count + W'(1);
			next_s.expired = (s.count + W'(1)) == tmr.limit;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tmr.expired = s.expired;
endmodule : delay_timer
`default_nettype wire

// File: rtl/load_switch_fault_sequencer.sv
// switch control and fault sequencing of a usb power load switch
// assumes analog comparators present level indications on pins;
// every pin input except the unused faultFlagNIn is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module load_switch_fault_sequencer
	import load_switch_pkg::*;
#(
	parameter int SC_CHECK_CYCLES = SC_CHECK_CYC,
	parameter int HICCUP_CYCLES = HICCUP_CYC,
	parameter int REPORT_CYCLES = REPORT_CYC,
	parameter int RELEASE_CYCLES = RELEASE_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic fastTurnOnSelect,
	input wire logic inputUndervoltageLockout,
	input wire logic overTemperature,
	input wire logic overcurrentTrip,
	input wire logic currentLimitRegulation,
	input wire logic outputBelowFortyPercent,
	input wire logic reverseVoltage,
	input wire logic faultFlagNIn,
	output logic switchOn,
	output logic softstartCurrentLimit,
	output logic limitEnable,
	output logic chargePumpOn,
	output logic faultFlagNOut,
	output logic faultFlagNOe
);
	// refuse counts that the timer width cannot hold
	if (SC_CHECK_CYCLES < 1 || SC_CHECK_CYCLES >= (1 << TIMER_W)) begin : g_chk_sc
		$error("short-circuit check count out of range");
	end
	if (HICCUP_CYCLES < 1 || HICCUP_CYCLES >= (1 << TIMER_W)) begin : g_chk_hic
		$error("hiccup count out of range");
	end
	if (REPORT_CYCLES < 1 || REPORT_CYCLES >= (1 << TIMER_W)) begin : g_chk_rep
		$error("report count out of range");
	end
	if (RELEASE_CYCLES < 1 || RELEASE_CYCLES >= (1 << TIMER_W)) begin : g_chk_rel
		$error("release count out of range");
	end
	// fixed package counts share the same timer width
	if (BLANK_CYC < 1 || BLANK_CYC >= (1 << TIMER_W)) begin : g_chk_blank
		$error("blanking count out of range");
	end
	if (RECOVER_CYC < 1 || RECOVER_CYC >= (1 << TIMER_W)) begin : g_chk_rec
		$error("recovery count out of range");
	end

	typedef struct packed {
		logic [IN_COUNT-1:0] sync1;
		logic [IN_COUNT-1:0] sync2;
		logic [IN_COUNT-1:0] sync3;
		logic [IN_COUNT-1:0] stable;
		seq_state_t state;
		logic fastMode;
		logic flag;
		logic switchOn;
		logic ssLimit;
		logic limitEnable;
		logic pumpOn;
		logic flagOe;
		logic flagLevel;
	} seq_regs_t;

	seq_regs_t s;
	seq_regs_t next_s;

	// faultFlagNIn readback is not used; the flag state is held internally
	logic [IN_COUNT-1:0] pins;
	logic en;
	logic fastOn;
	logic input_undervoltage_lockout;
	logic hot;
	logic overcurrent_trip;
	logic current_limit_regulation;
	logic outLow;
	logic reverse;
	logic faultNow;

	timer_if #(.W(TIMER_W)) scTmr ();
	timer_if #(.W(TIMER_W)) blankTmr ();
	timer_if #(.W(TIMER_W)) hiccupTmr ();
	timer_if #(.W(TIMER_W)) reportTmr ();
	timer_if #(.W(TIMER_W)) releaseTmr ();
	timer_if #(.W(TIMER_W)) recoverTmr ();

	// gather pins into one vector for the synchroniser
	always_comb begin
		pins = '0;
		pins[IN_ENABLE] = enable;
		pins[IN_FAST_ON] = fastTurnOnSelect;
		pins[IN_INPUT_UNDERVOLTAGE_LOCKOUT] = inputUndervoltageLockout;
		pins[IN_OVERTEMP] = overTemperature;
		pins[IN_OCP] = overcurrentTrip;
		pins[IN_CLP] = currentLimitRegulation;
		pins[IN_OUT_LOW] = outputBelowFortyPercent;
		pins[IN_REVERSE] = reverseVoltage;
	end

	// filtered levels, taken only once stages two and three agree
	assign en = s.stable[IN_ENABLE];
	assign fastOn = s.stable[IN_FAST_ON];
	assign input_undervoltage_lockout = s.stable[IN_INPUT_UNDERVOLTAGE_LOCKOUT];
	assign hot = s.stable[IN_OVERTEMP];
	assign overcurrent_trip = s.stable[IN_OCP];
	assign current_limit_regulation = s.stable[IN_CLP];
	assign outLow = s.stable[IN_OUT_LOW];
	assign reverse = s.stable[IN_REVERSE];

	// timer run levels follow the present state
	always_comb begin
		scTmr.limit = TIMER_W'(SC_CHECK_CYCLES);
		blankTmr.limit = TIMER_W'(BLANK_CYC);
		hiccupTmr.limit = TIMER_W'(HICCUP_CYCLES);
		reportTmr.limit = TIMER_W'(REPORT_CYCLES);
		releaseTmr.limit = TIMER_W'(RELEASE_CYCLES);
		recoverTmr.limit = TIMER_W'(RECOVER_CYC);
		scTmr.run = (s.state == ST_SOFTSTART) && !s.fastMode;
		blankTmr.run = (s.state == ST_SOFTSTART) && s.fastMode;
		hiccupTmr.run = (s.state == ST_HICCUP);
		reportTmr.run = (s.state == ST_ON) && current_limit_regulation;
		releaseTmr.run = s.flag && !faultNow;
		recoverTmr.run = (s.state == ST_RCP_WAIT) && !reverse;
	end

	// one timer per delay; all on the core clock
	// short-circuit check, slow start only
	delay_timer #(.W(TIMER_W)) u_scTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(scTmr)
	);

	// fast-start blanking of the limit loop
	delay_timer #(.W(TIMER_W)) u_blankTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(blankTmr)
	);

	// retry wait after any trip
	delay_timer #(.W(TIMER_W)) u_hiccupTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(hiccupTmr)
	);

	// persistence filter for limit events
	delay_timer #(.W(TIMER_W)) u_reportTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(reportTmr)
	);

	// hold-off before the flag lets go
	delay_timer #(.W(TIMER_W)) u_releaseTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(releaseTmr)
	);

	// reverse recovery, restarted by each new reverse spell
	delay_timer #(.W(TIMER_W)) u_recoverTimer (
		.clk(clk),
		.arst_n(arst_n),
		.tmr(recoverTmr)
	);

	// present fault condition that the flag must show
	always_comb begin
		faultNow = 1'b0;
		if (s.state == ST_HICCUP || s.state == ST_THERMAL) begin
			faultNow = 1'b1;
		end
		if (s.state == ST_ON && current_limit_regulation && reportTmr.expired) begin
			faultNow = 1'b1;
		end
	end

	// next-state logic for synchroniser, sequencer and outputs
	always_comb begin
		next_s = s;

		// three-stage synchroniser; stage one feeds stage two only
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		next_s.stable = (~(s.sync2 ^ s.sync3) & s.sync3)
			| ((s.sync2 ^ s.sync3) & s.stable);

		// sequencer
		unique case (s.state)
			ST_SHUTDOWN: begin
				// fast-on is taken only here; a change while on waits
				if (en && !input_undervoltage_lockout) begin
					next_s.fastMode = fastOn;
					next_s.state = ST_PRECHECK;
				end
			end
			ST_PRECHECK: begin
				if (hot) begin
					next_s.state = ST_THERMAL;
				end else if (reverse) begin
					next_s.state = ST_RCP_WAIT;
				end else begin
					next_s.state = ST_SOFTSTART;
				end
			end
			ST_RCP_WAIT: begin
				// recovery timer restarts whenever reverse returns
				if (hot) begin
					next_s.state = ST_THERMAL;
				end else if (recoverTmr.expired) begin
					next_s.state = ST_SOFTSTART;
				end
			end
			ST_SOFTSTART: begin
				if (hot) begin
					next_s.state = ST_THERMAL;
				end else if (overcurrent_trip) begin
					next_s.state = ST_HICCUP;
				end else if (s.fastMode && blankTmr.expired) begin
					next_s.state = ST_ON;
				end else if (!s.fastMode && scTmr.expired) begin
					// thermal was checked first, so only a short remains
					next_s.state = outLow ? ST_HICCUP : ST_ON;
				end
			end
			ST_ON: begin
				// limiting alone keeps the switch on; only a collapse trips
				if (hot) begin
					next_s.state = ST_THERMAL;
				end else if (overcurrent_trip) begin
					next_s.state = ST_HICCUP;
				end else if (current_limit_regulation && outLow) begin
					next_s.state = ST_HICCUP;
				end
			end
			ST_HICCUP: begin
				// the retry timer starts from zero on every entry
				if (hot) begin
					next_s.state = ST_THERMAL;
				end else if (hiccupTmr.expired) begin
					next_s.state = ST_SOFTSTART;
				end
			end
			ST_THERMAL: begin
				// the hysteresis lives in the comparator feeding this pin
				if (!hot) begin
					next_s.state = ST_HICCUP;
				end
			end
			default: begin
				next_s.state = ST_SHUTDOWN;
			end
		endcase

		// enable low or supply too low overrides every sequencer state
		if (!en || input_undervoltage_lockout) begin
			next_s.state = ST_SHUTDOWN;
		end

		// switch drive; reverse blocking opens it without any fault
		next_s.switchOn = (next_s.state == ST_SOFTSTART
			|| next_s.state == ST_ON) && !reverse;
		next_s.ssLimit = (next_s.state == ST_SOFTSTART)
			&& !next_s.fastMode;
		// regulation at the set limit is on in ST_ON and in slow soft start, off during fast-start blanking
		next_s.limitEnable = (next_s.state == ST_ON)
			|| (next_s.state == ST_SOFTSTART && !next_s.fastMode);
		next_s.pumpOn = en;

		// fault flag: immediate for trips, held until release runs out, cleared at once in shutdown
		if (next_s.state == ST_SHUTDOWN) begin
			next_s.flag = 1'b0;
		end else if (next_s.state == ST_HICCUP
			|| next_s.state == ST_THERMAL) begin
			next_s.flag = 1'b1;
		end else if (faultNow) begin
			next_s.flag = 1'b1;
		end else if (s.flag && releaseTmr.expired) begin
			next_s.flag = 1'b0;
		end
		next_s.flagOe = next_s.flag;
		// open drain: the data bit only ever pulls the line low
		next_s.flagLevel = 1'b0;
	end

	// single register stage for all state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '{
				sync1: '0,
				sync2: '0,
				sync3: '0,
				stable: '0,
				state: ST_SHUTDOWN,
				fastMode: 1'b0,
				flag: 1'b0,
				switchOn: 1'b0,
				ssLimit: 1'b0,
				limitEnable: 1'b0,
				pumpOn: 1'b0,
				flagOe: 1'b0,
				flagLevel: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from flops; open drain only ever pulls low
	assign switchOn = s.switchOn;
	assign softstartCurrentLimit = s.ssLimit;
	assign limitEnable = s.limitEnable;
	assign chargePumpOn = s.pumpOn;
	assign faultFlagNOut = s.flagLevel;
	assign faultFlagNOe = s.flagOe;
endmodule : load_switch_fault_sequencer
`default_nettype wire

// File: tb/load_switch_asserts.sv
// port checker for the load switch fault sequencer, bound to its top
// assumes fault inputs are held for several cycles, past the input filter
`timescale 1ns/1ps
`default_nettype none
module load_switch_asserts #(
	parameter int HICCUP_CYCLES = 40,
	parameter int REPORT_CYCLES = 25,
	parameter int RELEASE_CYCLES = 30
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic inputUndervoltageLockout,
	input wire logic overTemperature,
	input wire logic overcurrentTrip,
	input wire logic currentLimitRegulation,
	input wire logic outputBelowFortyPercent,
	input wire logic switchOn,
	input wire logic softstartCurrentLimit,
	input wire logic limitEnable,
	input wire logic chargePumpOn,
	input wire logic faultFlagNOut,
	input wire logic faultFlagNOe
);
	int offCnt;
	int clpCnt;
	int quietCnt;
	logic anyFault;
	logic clpOnly;
	assign anyFault = overTemperature | overcurrentTrip | currentLimitRegulation;
	assign clpOnly = currentLimitRegulation & switchOn & ~overTemperature
		& ~overcurrentTrip & ~outputBelowFortyPercent;
	// run lengths; quiet time starts before the sync lag, so bounds stay safe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			offCnt <= 0;
			clpCnt <= 0;
			quietCnt <= 0;
		end else begin
			offCnt <= switchOn ? 0 : offCnt + 1;
			clpCnt <= clpOnly ? clpCnt + 1 : 0;
			quietCnt <= anyFault ? 0 : quietCnt + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence onSteady;
		switchOn && limitEnable && !softstartCurrentLimit && !overcurrentTrip;
	endsequence
	sequence ocpHeld;
		(overcurrentTrip && enable)[*6];
	endsequence
	chk_drain_only: assert property (faultFlagNOe |-> !faultFlagNOut)
		else $error("flag pin driven high");
	chk_idle_off: assert property ((!enable)[*8] |->
		!switchOn && !faultFlagNOe && !chargePumpOn) else $error("idle not off");
	chk_input_undervoltage_lockout_hold: assert property (inputUndervoltageLockout[*8] |->
		!switchOn) else $error("switch on in lockout");
	chk_pump_on: assert property (enable[*8] |-> chargePumpOn)
		else $error("pump off while enabled");
	chk_thermal_off: assert property ((enable && overTemperature
		&& !inputUndervoltageLockout)[*8] |-> !switchOn && faultFlagNOe)
		else $error("thermal not handled");
	chk_ocp_trip: assert property (onSteady ##1 ocpHeld |=>
		!switchOn && faultFlagNOe) else $error("trip not handled");
	chk_hiccup_wait: assert property ($rose(switchOn) && faultFlagNOe |->
		offCnt >= HICCUP_CYCLES) else $error("retry too early");
	chk_report_late: assert property (clpCnt == REPORT_CYCLES + 10 |->
		faultFlagNOe && switchOn) else $error("limit not reported");
	chk_report_early: assert property ($rose(faultFlagNOe) && clpCnt > 6 |->
		clpCnt >= REPORT_CYCLES) else $error("limit reported early");
	chk_release_hold: assert property ($fell(faultFlagNOe) && enable |->
		quietCnt >= RELEASE_CYCLES) else $error("flag released early");
endmodule : load_switch_asserts
bind load_switch_fault_sequencer load_switch_asserts #(
	.HICCUP_CYCLES(HICCUP_CYCLES),
	.REPORT_CYCLES(REPORT_CYCLES),
	.RELEASE_CYCLES(RELEASE_CYCLES)
) checker_inst (
	.clk, .arst_n, .enable, .inputUndervoltageLockout, .overTemperature,
	.overcurrentTrip, .currentLimitRegulation, .outputBelowFortyPercent,
	.switchOn, .softstartCurrentLimit, .limitEnable, .chargePumpOn,
	.faultFlagNOut, .faultFlagNOe
);
`default_nettype wire

// File: tb/controller_model.sv
// system controller: drives enable and fast-on, reads the fault pin
// assumes a pull-up on the fault line and the core clock for its logic
`timescale 1ns/1ps
`default_nettype none
module controller_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wantOn,
	input wire logic wantFast,
	input wire logic faultFlagNOut,
	input wire logic faultFlagNOe,
	output logic enable,
	output logic fastTurnOnSelect,
	output logic faultPin
);
	// pull-up wins whenever the sequencer lets go of the flag
	assign faultPin = faultFlagNOe ? faultFlagNOut : 1'b1;
	// mode is updated with enable; bench sets it ahead of the rise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enable <= 1'b0;
			fastTurnOnSelect <= 1'b0;
		end else begin
			enable <= wantOn;
			fastTurnOnSelect <= wantFast;
		end
	end
endmodule : controller_model
`default_nettype wire

// File: tb/testbench.sv
// bench for the load switch fault sequencer with short delay counts
// assumes the controller model drives enable and fast-on
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int SC = 20;
	localparam int HIC = 40;
	localparam int REP = 25;
	localparam int REL = 30;
	logic clk = 0, arst_n = 0, wantOn = 0, wantFast = 0, input_undervoltage_lockout = 0, ot = 0;
	logic overcurrent_trip = 0, current_limit_regulation = 0, outLow = 0, rev = 0;
	logic enable, fastTurnOnSelect, faultPin, switchOn, softstartCurrentLimit;
	logic limitEnable, chargePumpOn, faultFlagNOut, faultFlagNOe;
	int seed = 38584, errCount = 0, compares = 0, cycles = 0, len;
	controller_model partner (.clk, .arst_n, .wantOn, .wantFast,
		.faultFlagNOut, .faultFlagNOe, .enable, .fastTurnOnSelect, .faultPin);
	load_switch_fault_sequencer #(.SC_CHECK_CYCLES(SC), .HICCUP_CYCLES(HIC),
		.REPORT_CYCLES(REP), .RELEASE_CYCLES(REL)) dut (
		.clk, .arst_n, .enable, .fastTurnOnSelect,
		.inputUndervoltageLockout(input_undervoltage_lockout), .overTemperature(ot),
		.overcurrentTrip(overcurrent_trip), .currentLimitRegulation(current_limit_regulation),
		.outputBelowFortyPercent(outLow), .reverseVoltage(rev),
		.faultFlagNIn(faultPin), .switchOn, .softstartCurrentLimit,
		.limitEnable, .chargePumpOn, .faultFlagNOut, .faultFlagNOe);
	always #50 clk = ~clk;
	// open-drain pin level for an asserted or idle fault
	function automatic logic pin(input logic asserted);
		return !asserted;
	endfunction : pin
	task automatic at(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : at
	task automatic chk(input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t: saw %b want %b", $time, seen, exp);
		end
	endtask : chk
	task automatic printVerdict;
		$display("errors %0d, checks %0d", errCount, compares);
		if (errCount == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : printVerdict
	// hang guard well past the longest sequence
	always @(posedge clk) begin
		cycles++;
		if (cycles == 9000) begin
			errCount++;
			printVerdict;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk) wantOn <= 1'b1;
		at(10);
		chk(switchOn, 1'b1);
		chk(softstartCurrentLimit, 1'b1);
		chk(chargePumpOn, 1'b1);
		at(SC + 10);
		chk(softstartCurrentLimit, 1'b0);
		// random limiting bursts, all shorter than the report delay
		repeat (3) begin
			len = 4 + {$random(seed)} % 12;
			@(posedge clk) current_limit_regulation <= 1'b1;
			repeat (len) @(posedge clk);
			current_limit_regulation <= 1'b0;
			at(10);
			chk(faultPin, pin(1'b0));
		end
		@(posedge clk) current_limit_regulation <= 1'b1;
		at(REP - 5);
		chk(faultPin, pin(1'b0));
		at(20);
		chk(faultPin, pin(1'b1));
		chk(switchOn, 1'b1);
		@(posedge clk) current_limit_regulation <= 1'b0;
		at(REL - 5);
		chk(faultPin, pin(1'b1));
		at(20);
		chk(faultPin, pin(1'b0));
		// trip held six cycles so the trip assertion sees it whole
		@(posedge clk) overcurrent_trip <= 1'b1;
		repeat (6) @(posedge clk);
		overcurrent_trip <= 1'b0;
		at(8);
		chk(switchOn, 1'b0);
		chk(faultPin, pin(1'b1));
		at(HIC - 10);
		chk(switchOn, 1'b0);
		at(30);
		chk(switchOn, 1'b1);
		at(100);
		@(posedge clk) ot <= 1'b1;
		at(8);
		chk(switchOn, 1'b0);
		chk(faultPin, pin(1'b1));
		@(posedge clk) ot <= 1'b0;
		at(HIC - 10);
		chk(faultPin, pin(1'b1));
		at(60);
		chk(switchOn, 1'b1);
		at(40);
		chk(faultPin, pin(1'b0));
		@(posedge clk) current_limit_regulation <= 1'b1;
		outLow <= 1'b1;
		at(10);
		chk(switchOn, 1'b0);
		@(posedge clk) current_limit_regulation <= 1'b0;
		outLow <= 1'b0;
		at(150);
		chk(switchOn, 1'b1);
		@(posedge clk) wantOn <= 1'b0;
		at(10);
		chk(switchOn | !faultPin, 1'b0);
		@(posedge clk) outLow <= 1'b1;
		wantOn <= 1'b1;
		at(SC + 15);
		chk(faultPin | switchOn, 1'b0);
		@(posedge clk) outLow <= 1'b0;
		at(HIC + 10);
		chk(switchOn, 1'b1);
		at(100);
		@(posedge clk) wantOn <= 1'b0;
		at(10);
		@(posedge clk) rev <= 1'b1;
		wantOn <= 1'b1;
		at(20);
		chk(switchOn, 1'b0);
		chk(faultPin, pin(1'b0));
		chk(chargePumpOn, 1'b1);
		@(posedge clk) rev <= 1'b0;
		at(140);
		chk(switchOn, 1'b0);
		at(40);
		chk(switchOn, 1'b1);
		@(posedge clk) rev <= 1'b1;
		at(10);
		chk(switchOn | !faultPin, 1'b0);
		@(posedge clk) rev <= 1'b0;
		at(10);
		chk(switchOn, 1'b1);
		@(posedge clk) input_undervoltage_lockout <= 1'b1;
		at(10);
		chk(switchOn, 1'b0);
		@(posedge clk) input_undervoltage_lockout <= 1'b0;
		wantOn <= 1'b0;
		wantFast <= 1'b1;
		at(10);
		@(posedge clk) wantOn <= 1'b1;
		at(20);
		chk(switchOn & !softstartCurrentLimit, 1'b1);
		chk(limitEnable, 1'b0);
		at(3700);
		chk(limitEnable, 1'b1);
		// reset in mid-run drops everything back to shutdown
		@(posedge clk) arst_n <= 1'b0;
		at(2);
		chk(switchOn | limitEnable | chargePumpOn | !faultPin, 1'b0);
		@(posedge clk) arst_n <= 1'b1;
		at(20);
		chk(switchOn, 1'b1);
		printVerdict;
	end
endmodule : testbench
`default_nettype wire
